/* File: hdl/ism_pkg.sv */
/*
  Shared constants and types of the I2C slave peripheral map: byte
  locations of the peripheral space, bit counts, state encoding and
  the structs carried on the internal register bus.
  Assumes nothing beyond a SystemVerilog-2012 compiler.
*/
package ism_pkg;

  // Peripheral byte locations (first and top bytes of words, ends of the space, step)
  localparam logic [7:0] PA_WADDR = 8'h00;
  localparam logic [7:0] PA_WDATA = 8'h04;
  localparam logic [7:0] PA_WDATA_TOP = 8'h07;
  localparam logic [7:0] PA_RADDR = 8'h10;
  localparam logic [7:0] PA_RDATA = 8'h14;
  localparam logic [7:0] PA_RDATA_TOP = 8'h17;
  localparam logic [7:0] PA_ACC_STAT = 8'h20;
  localparam logic [7:0] PA_ACC_CTRL = 8'h24;
  localparam logic [7:0] PA_STAT_SUM = 8'h80;
  localparam logic [7:0] PA_STAT_EN = 8'h84;
  localparam logic [7:0] PA_MBOX_OUT = 8'h90;
  localparam logic [7:0] PA_MBOX_IN = 8'h94;
  localparam logic [7:0] PA_LAST = 8'hFF;
  localparam logic [7:0] PA_FIRST = 8'h00;
  localparam logic [7:0] PA_STEP = 8'h01;

  // Bit counter marks
  localparam logic [3:0] BIT_ZERO = 4'h0;
  localparam logic [3:0] BIT_ONE = 4'h1;
  localparam logic [3:0] BIT_TX_LAST = 4'h7;
  localparam logic [3:0] BIT_FULL = 4'h8;

  // Reset values and fixed fields
  localparam logic [31:0] WORD_RESET = 32'h0000_0000;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [1:0] ALIGN_ZERO = 2'h0;
  localparam logic [6:0] GEN_CALL_ADDR = 7'h00;

  // Transfer phases of the slave engine
  typedef enum logic [3:0] {
    PH_IDLE, PH_ADDR, PH_ADDR_ACK, PH_WRX, PH_WACK, PH_WBUSY,
    PH_RLOAD, PH_RFETCH, PH_RSEND, PH_RTX, PH_RACK
  } ism_phase_t;

  // Internal register bus request
  typedef struct packed {
    logic valid;
    logic we;
    logic [31:0] addr;
    logic [31:0] wdata;
  } ism_ibus_req_t;

  // Internal register bus answer
  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
  } ism_ibus_rsp_t;

  // Words held locally in the interface
  typedef struct packed {
    logic [31:0] waddr;
    logic [31:0] wdata;
    logic [31:0] raddr;
    logic [31:0] rdata;
    logic [31:0] actrl;
    logic [31:0] stat_en;
    logic [31:0] mbox_out;
    logic [31:0] mbox_in;
  } ism_regs_t;

endpackage

/* File: hdl/ism_sync3.sv */
/*
  Three-stage synchroniser with agreement filter for one pin.
  Assumes the pin is asynchronous to clk; the output changes only
  when the second and third stages agree.
*/
`timescale 1ns/100ps
`default_nettype none
module ism_sync3 #(
  parameter logic RST_VAL = 1'b1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Pin and filtered level
  input wire logic pin,
  output logic level
);

  // All stages of the synchroniser
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic lvl;
  } ism_sync_t;

  ism_sync_t sync_ff;
  ism_sync_t nxt_sync;

  // Shift chain; first stage feeds only the second
  always_comb begin
    nxt_sync = sync_ff;
    nxt_sync.s1 = pin;
    nxt_sync.s2 = sync_ff.s1;
    nxt_sync.s3 = sync_ff.s2;
    // Accept a change only once two stages agree
    if (sync_ff.s2 == sync_ff.s3) begin
      nxt_sync.lvl = sync_ff.s3;
    end
  end

  // Bus idles high, so reset to the idle level
  always_ff @(posedge clk) begin
    if (!resetn) begin
      sync_ff <= '{s1: RST_VAL, s2: RST_VAL, s3: RST_VAL, lvl: RST_VAL};
    end else begin
      sync_ff <= nxt_sync;
    end
  end

  assign level = sync_ff.lvl;

endmodule
`default_nettype wire

/* File: hdl/ism_top.sv */
/*
  I2C slave peripheral map: a bit-level I2C slave that exposes a
  256-byte peripheral space of local words, with triggered internal
  register bus reads and writes and SCL stretching while they run.
  Assumes SCL and SDA pins are open drain with external pull-ups and
  that the internal bus answers each request with one ack pulse.
*/
//
// Functional notes
// - Lowest byte location holds word's least byte
// - Pointer may select any byte location
// - Byte accesses use local storage only
// - Unmapped read gives zero, write ignored
// - Pointer steps after every byte
// - Bytes 0x00-0x03 hold write address
// - Write at 0x07 launches write, rewinds
// - Read at 0x07 steps, no write
// - Bytes 0x10-0x13 hold read address
// - Read at 0x14 fetches word first
// - Read at 0x17 rewinds to 0x14
// - Write at 0x17 steps to 0x18
// - Bytes 0x20-0x23 read-only access status
// - Bytes 0x24-0x27 read/write access control
// - Bytes 0x80-0x83 read-only status summary
// - Enabled summary bits alone raise alert
// - Outgoing mailbox: processor writes, master reads
// - Incoming mailbox: master writes and reads back
// - Pointer wraps from 0xFF to 0x00
// - Unlisted ranges map to no word
// - Read without pointer starts where left
`timescale 1ns/100ps
`default_nettype none
module ism_top
  import ism_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // I2C pins, oe low while driving low
  input wire logic scl_i,
  output logic scl_oe_n,
  input wire logic sda_i,
  output logic sda_oe_n,
  // Slave address
  input wire logic [6:0] slave_addr,
  // Internal register bus
  output ism_ibus_req_t ibus_req,
  input wire ism_ibus_rsp_t ibus_rsp,
  // Processor side words
  input wire logic [31:0] status_summary,
  input wire logic [31:1] access_status_in,
  input wire logic mbox_out_we,
  input wire logic [31:0] mbox_out_wdata,
  output logic [31:0] incoming_mailbox,
  output logic [31:0] access_control,
  output logic alert
);

  ////////////////////////////////////////////////////////////////////
  // State

  // Whole state of the block
  typedef struct packed {
    ism_phase_t phase;
    logic [3:0] cnt;
    logic [7:0] shreg;
    logic rw;
    logic first;
    logic nack;
    logic [7:0] ptr;
    logic scl_prev;
    logic sda_prev;
    logic sda_oe_n;
    logic scl_oe_n;
    logic alert;
    ism_regs_t regs;
    ism_ibus_req_t ibus;
  } ism_state_t;

  ism_state_t state_ff;
  ism_state_t nxt_state;
  logic scl_lvl; // Filtered SCL
  logic sda_lvl; // Filtered SDA
  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;
  logic wr_evt; // Data byte written at ptr
  logic rd_evt; // Data byte read at ptr
  logic [31:0] acc_stat; // Access status word
  logic [223:0] ext_words; // Master-visible words, processor mailbox left out

  ////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  ism_sync3 #(.RST_VAL(1'b1)) u_scl_sync (
    .clk(clk),
    .resetn(resetn),
    .pin(scl_i),
    .level(scl_lvl)
  );

  ism_sync3 #(.RST_VAL(1'b1)) u_sda_sync (
    .clk(clk),
    .resetn(resetn),
    .pin(sda_i),
    .level(sda_lvl)
  );

  // Bus events from filtered levels
  assign scl_rise = scl_lvl && !state_ff.scl_prev;
  assign scl_fall = !scl_lvl && state_ff.scl_prev;
  assign bus_start = scl_lvl && state_ff.scl_prev && !sda_lvl && state_ff.sda_prev;
  assign bus_stop = scl_lvl && state_ff.scl_prev && sda_lvl && !state_ff.sda_prev;
  assign wr_evt = (state_ff.phase == PH_WRX) && scl_fall && !bus_start && !bus_stop
                  && (state_ff.cnt == BIT_FULL) && !state_ff.first;
  assign rd_evt = (state_ff.phase == PH_RSEND);
  assign acc_stat = {access_status_in, state_ff.alert};
  // Words a master write may touch; the outgoing mailbox moves on its own
  assign ext_words = {state_ff.regs.waddr, state_ff.regs.wdata, state_ff.regs.raddr,
                      state_ff.regs.rdata, state_ff.regs.actrl, state_ff.regs.stat_en,
                      state_ff.regs.mbox_in};

  ////////////////////////////////////////////////////////////////////
  // Helpers

  // byte lane select, least byte lowest
  function automatic logic [7:0] lane_get(input logic [31:0] w, input logic [1:0] l);
    lane_get = w[{l, 3'b000} +: 8];
  endfunction

  // Replace one byte lane of a word
  function automatic logic [31:0] lane_put(input logic [31:0] w, input logic [1:0] l,
                                           input logic [7:0] b);
    lane_put = w;
    lane_put[{l, 3'b000} +: 8] = b;
  endfunction

  function automatic logic [7:0] ptr_next(input logic [7:0] p, input logic is_wr);
    if (is_wr && p == PA_WDATA_TOP) begin
      ptr_next = PA_WDATA;
    end else if (!is_wr && p == PA_RDATA_TOP) begin
      ptr_next = PA_RDATA;
    end else if (p == PA_LAST) begin
      ptr_next = PA_FIRST;
    end else begin
      ptr_next = p + PA_STEP;
    end
  endfunction

  function automatic logic [7:0] rd_byte(input ism_regs_t r, input logic [31:0] st,
                                         input logic [31:0] sum, input logic [7:0] p);
    logic [7:0] base;
    base = {p[7:2], ALIGN_ZERO};
    unique case (base)
      PA_WADDR: rd_byte = lane_get(r.waddr, p[1:0]);
      PA_WDATA: rd_byte = lane_get(r.wdata, p[1:0]);
      PA_RADDR: rd_byte = lane_get(r.raddr, p[1:0]);
      PA_RDATA: rd_byte = lane_get(r.rdata, p[1:0]);
      PA_ACC_STAT: rd_byte = lane_get(st, p[1:0]);
      PA_ACC_CTRL: rd_byte = lane_get(r.actrl, p[1:0]);
      PA_STAT_SUM: rd_byte = lane_get(sum, p[1:0]);
      PA_STAT_EN: rd_byte = lane_get(r.stat_en, p[1:0]);
      PA_MBOX_OUT: rd_byte = lane_get(r.mbox_out, p[1:0]);
      PA_MBOX_IN: rd_byte = lane_get(r.mbox_in, p[1:0]);
      default: rd_byte = BYTE_ZERO;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////
  // Next state

  // Slave engine, map writes and internal bus
  always_comb begin
    logic [7:0] base;
    base = {state_ff.ptr[7:2], ALIGN_ZERO};
    nxt_state = state_ff;
    nxt_state.scl_prev = scl_lvl;
    nxt_state.sda_prev = sda_lvl;
    nxt_state.alert = |(status_summary & state_ff.regs.stat_en);
    if (mbox_out_we) begin
      nxt_state.regs.mbox_out = mbox_out_wdata;
    end
    if (bus_start) begin
      // Start or restart always re-arms address phase
      nxt_state.phase = PH_ADDR;
      nxt_state.cnt = BIT_ZERO;
      nxt_state.sda_oe_n = 1'b1;
    end else if (bus_stop) begin
      nxt_state.phase = PH_IDLE;
      nxt_state.sda_oe_n = 1'b1;
    end else begin
      unique case (state_ff.phase)
        PH_IDLE: begin
          nxt_state.sda_oe_n = 1'b1;
        end
        PH_ADDR: begin
          // Shift address bits on rising SCL
          if (scl_rise) begin
            nxt_state.shreg = {state_ff.shreg[6:0], sda_lvl};
            nxt_state.cnt = state_ff.cnt + BIT_ONE;
          end else if (scl_fall && state_ff.cnt == BIT_FULL) begin
            if (state_ff.shreg[7:1] == slave_addr && slave_addr != GEN_CALL_ADDR) begin
              nxt_state.rw = state_ff.shreg[0];
              nxt_state.sda_oe_n = 1'b0;
              nxt_state.phase = PH_ADDR_ACK;
            end else begin
              nxt_state.phase = PH_IDLE;
            end
          end
        end
        PH_ADDR_ACK: begin
          if (scl_fall) begin
            nxt_state.sda_oe_n = 1'b1;
            nxt_state.cnt = BIT_ZERO;
            // reads start at the kept pointer
            nxt_state.phase = state_ff.rw ? PH_RLOAD : PH_WRX;
            // first written byte is the pointer
            nxt_state.first = 1'b1;
          end
        end
        PH_WRX: begin
          if (scl_rise) begin
            nxt_state.shreg = {state_ff.shreg[6:0], sda_lvl};
            nxt_state.cnt = state_ff.cnt + BIT_ONE;
          end else if (scl_fall && state_ff.cnt == BIT_FULL) begin
            nxt_state.sda_oe_n = 1'b0;
            nxt_state.phase = PH_WACK;
            if (state_ff.first) begin
              nxt_state.ptr = state_ff.shreg;
              nxt_state.first = 1'b0;
            end else begin
              // local byte writes, no bus cycle
              unique case (base)
                PA_WADDR: nxt_state.regs.waddr =
                  lane_put(state_ff.regs.waddr, state_ff.ptr[1:0], state_ff.shreg);
                PA_WDATA: nxt_state.regs.wdata =
                  lane_put(state_ff.regs.wdata, state_ff.ptr[1:0], state_ff.shreg);
                PA_RADDR: nxt_state.regs.raddr =
                  lane_put(state_ff.regs.raddr, state_ff.ptr[1:0], state_ff.shreg);
                PA_ACC_CTRL: nxt_state.regs.actrl =
                  lane_put(state_ff.regs.actrl, state_ff.ptr[1:0], state_ff.shreg);
                PA_STAT_EN: nxt_state.regs.stat_en =
                  lane_put(state_ff.regs.stat_en, state_ff.ptr[1:0], state_ff.shreg);
                PA_MBOX_IN: nxt_state.regs.mbox_in =
                  lane_put(state_ff.regs.mbox_in, state_ff.ptr[1:0], state_ff.shreg);
                // unmapped write only moves pointer
                // Keep a coincident processor mailbox load
                default: begin
                end
              endcase
              // top write byte launches bus write
              if (state_ff.ptr == PA_WDATA_TOP) begin
                nxt_state.ibus.valid = 1'b1;
                nxt_state.ibus.we = 1'b1;
                nxt_state.ibus.addr = {state_ff.regs.waddr[31:2], ALIGN_ZERO};
                nxt_state.ibus.wdata = lane_put(state_ff.regs.wdata, state_ff.ptr[1:0],
                                                state_ff.shreg);
                nxt_state.scl_oe_n = 1'b0;
                nxt_state.phase = PH_WBUSY;
              end
              // wrap at the top of space
              nxt_state.ptr = ptr_next(state_ff.ptr, 1'b1);
            end
          end
        end
        PH_WBUSY: begin
          // Hold SCL low until the write completes
          if (ibus_rsp.ack) begin
            nxt_state.ibus.valid = 1'b0;
            nxt_state.scl_oe_n = 1'b1;
            nxt_state.phase = PH_WACK;
          end
        end
        PH_WACK: begin
          if (scl_fall) begin
            nxt_state.sda_oe_n = 1'b1;
            nxt_state.cnt = BIT_ZERO;
            nxt_state.phase = PH_WRX;
          end
        end
        PH_RLOAD: begin
          // fetch word before its first byte
          if (state_ff.ptr == PA_RDATA) begin
            nxt_state.ibus.valid = 1'b1;
            nxt_state.ibus.we = 1'b0;
            nxt_state.ibus.addr = {state_ff.regs.raddr[31:2], ALIGN_ZERO};
            nxt_state.scl_oe_n = 1'b0;
            nxt_state.phase = PH_RFETCH;
          end else begin
            // Brief stretch: first bit and SCL release then move together
            nxt_state.scl_oe_n = 1'b0;
            nxt_state.phase = PH_RSEND;
          end
        end
        PH_RFETCH: begin
          if (ibus_rsp.ack) begin
            nxt_state.regs.rdata = ibus_rsp.rdata;
            nxt_state.ibus.valid = 1'b0;
            // SCL stays low until the first bit stands on SDA
            nxt_state.phase = PH_RSEND;
          end
        end
        PH_RSEND: begin
          // summary and other words read locally
          nxt_state.shreg = rd_byte(state_ff.regs, acc_stat, status_summary, state_ff.ptr);
          nxt_state.sda_oe_n = rd_byte(state_ff.regs, acc_stat, status_summary,
                                       state_ff.ptr) >> 7 == BYTE_ZERO ? 1'b0 : 1'b1;
          nxt_state.cnt = BIT_ZERO;
          // Release SCL with the first bit, never before it
          nxt_state.scl_oe_n = 1'b1;
          nxt_state.ptr = ptr_next(state_ff.ptr, 1'b0);
          nxt_state.phase = PH_RTX;
        end
        PH_RTX: begin
          // Shift out on falling SCL, MSB first
          if (scl_fall) begin
            if (state_ff.cnt == BIT_TX_LAST) begin
              nxt_state.sda_oe_n = 1'b1;
              nxt_state.phase = PH_RACK;
            end else begin
              nxt_state.shreg = {state_ff.shreg[6:0], 1'b0};
              nxt_state.sda_oe_n = state_ff.shreg[6];
              nxt_state.cnt = state_ff.cnt + BIT_ONE;
            end
          end
        end
        PH_RACK: begin
          if (scl_rise) begin
            nxt_state.nack = sda_lvl;
          end else if (scl_fall) begin
            nxt_state.phase = state_ff.nack ? PH_IDLE : PH_RLOAD;
          end
        end
      endcase
    end
  end

  // Register the state
  always_ff @(posedge clk) begin
    if (!resetn) begin
      nxt_state_rst: begin
        state_ff <= '0;
        state_ff.phase <= PH_IDLE;
        state_ff.scl_prev <= 1'b1;
        state_ff.sda_prev <= 1'b1;
        state_ff.sda_oe_n <= 1'b1;
        state_ff.scl_oe_n <= 1'b1;
      end
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Outputs straight from the state register
  assign scl_oe_n = state_ff.scl_oe_n;
  assign sda_oe_n = state_ff.sda_oe_n;
  assign ibus_req = state_ff.ibus;
  assign incoming_mailbox = state_ff.regs.mbox_in;
  assign access_control = state_ff.regs.actrl;
  assign alert = state_ff.alert;

  ////////////////////////////////////////////////////////////////////
  // Assertions

  wdata_rewind_a: assert property (@(posedge clk) disable iff (!resetn)
    wr_evt && state_ff.ptr == PA_WDATA_TOP |=> state_ff.ptr == PA_WDATA)
    else $error("pointer did not rewind after top write byte");

  wdata_launch_a: assert property (@(posedge clk) disable iff (!resetn)
    wr_evt && state_ff.ptr == PA_WDATA_TOP |=> ibus_req.valid && ibus_req.we
      && ibus_req.addr == {$past(state_ff.regs.waddr[31:2]), ALIGN_ZERO})
    else $error("internal write not launched to held address");

  wdata_read_step_a: assert property (@(posedge clk) disable iff (!resetn)
    rd_evt && state_ff.ptr == PA_WDATA_TOP |=> state_ff.ptr == 8'h08 && !ibus_req.valid)
    else $error("read of top write byte misbehaved");

  rdata_rewind_a: assert property (@(posedge clk) disable iff (!resetn)
    rd_evt && state_ff.ptr == PA_RDATA_TOP |=> state_ff.ptr == PA_RDATA)
    else $error("pointer did not rewind after top read byte");

  rdata_wr_step_a: assert property (@(posedge clk) disable iff (!resetn)
    wr_evt && state_ff.ptr == PA_RDATA_TOP |=> state_ff.ptr == 8'h18 && $stable(ext_words))
    else $error("write at top read byte did not step");

  ptr_wrap_a: assert property (@(posedge clk) disable iff (!resetn)
    (wr_evt || rd_evt) && state_ff.ptr == PA_LAST |=> state_ff.ptr == PA_FIRST)
    else $error("pointer did not wrap");

  rdata_fetch_a: assert property (@(posedge clk) disable iff (!resetn)
    state_ff.phase == PH_RLOAD && state_ff.ptr == PA_RDATA
      |=> ibus_req.valid && !ibus_req.we && !scl_oe_n && !rd_evt ##[1:1000] rd_evt)
    else $error("read word not fetched before its first byte");

  rdata_order_a: assert property (@(posedge clk) disable iff (!resetn)
    rd_evt && state_ff.ptr == PA_RDATA |-> $past(state_ff.phase) == PH_RFETCH)
    else $error("read word byte sent without a fetch");

  unmapped_zero_a: assert property (@(posedge clk) disable iff (!resetn)
    rd_evt && state_ff.ptr inside {[8'h08:8'h0F], [8'h18:8'h1F], [8'h28:8'h7F],
      [8'h88:8'h8F], [8'h98:8'hFF]} |=> state_ff.shreg == BYTE_ZERO && !sda_oe_n)
    else $error("unmapped read returned nonzero");

  alert_mask_a: assert property (@(posedge clk) disable iff (!resetn)
    (status_summary & state_ff.regs.stat_en) == WORD_RESET |=> !alert)
    else $error("alert raised by a disabled summary bit");

  ro_write_a: assert property (@(posedge clk) disable iff (!resetn)
    wr_evt && state_ff.ptr inside {[8'h14:8'h17], [8'h20:8'h23], [8'h80:8'h83],
      [8'h90:8'h93]} |=> $stable(ext_words))
    else $error("read-only word changed by a write");

  wr_trigger_c: cover property (@(posedge clk) disable iff (!resetn)
    wr_evt && state_ff.ptr == PA_WDATA_TOP ##[1:1000] ibus_rsp.ack);
  rd_fetch_c: cover property (@(posedge clk) disable iff (!resetn)
    state_ff.phase == PH_RFETCH && ibus_rsp.ack);
  wrap_c: cover property (@(posedge clk) disable iff (!resetn)
    rd_evt && state_ff.ptr == PA_LAST);

endmodule
`default_nettype wire

/* File: tb/ism_i2c_master.sv */
/*
  Bit-level I2C bus master model with start, stop and byte tasks.
  Assumes pull-ups on both lines; the slave may stretch SCL low.
*/
`timescale 1ns/100ps
`default_nettype none
module ism_i2c_master (
  // Wire levels
  input wire logic scl,
  input wire logic sda,
  // Pull-low enables, low while driving
  output logic scl_oe_n,
  output logic sda_oe_n
);
  // Quarter of the 125 ns bit period
  localparam real Q = 31.25;
  // Lines released while idle
  initial begin
    scl_oe_n = 1'b1;
    sda_oe_n = 1'b1;
  end
  ////////////////////////////////////////
  // Release SCL, wait out any stretch
  task automatic rise();
    scl_oe_n = 1'b1;
    while (scl !== 1'b1) #1;
    #(Q);
  endtask
  // Start, or restart from SCL low
  task automatic start();
    sda_oe_n = 1'b1;
    #(2*Q);
    rise();
    sda_oe_n = 1'b0;
    #(Q);
    scl_oe_n = 1'b0;
  endtask
  task automatic stop();
    sda_oe_n = 1'b0;
    #(2*Q);
    rise();
    sda_oe_n = 1'b1;
    #(2*Q);
  endtask
  // Sample midway through the high phase, after the slave settled
  task automatic bit_io(input logic b, output logic r);
    sda_oe_n = b;
    #(2*Q);
    rise();
    r = sda;
    #(Q);
    scl_oe_n = 1'b0;
  endtask
  // Eight bits MSB first, then the acknowledge slot
  task automatic byte_io(input logic [7:0] d, input logic ab, output logic [7:0] r,
                         output logic ar);
    for (int i = 7; i >= 0; i--) bit_io(d[i], r[i]);
    bit_io(ab, ar);
  endtask
endmodule
`default_nettype wire

/* File: tb/tb.sv */
/*
  Self-checking bench of the peripheral map, driven over I2C.
  Assumes the master model file; the bench plays the internal bus.
*/
`timescale 1ns/100ps
`default_nettype none
module tb;
  import ism_pkg::*;
  // Slave address, arbitrary
  localparam logic [6:0] SADDR = 7'h2A;
  logic clk, resetn, scl_oe_n, sda_oe_n, m_scl_oe_n, m_sda_oe_n;
  // Open drain wires with pull-ups
  wire logic scl = scl_oe_n & m_scl_oe_n;
  wire logic sda = sda_oe_n & m_sda_oe_n;
  ism_ibus_req_t ibus_req;
  ism_ibus_rsp_t ibus_rsp = '0;
  logic [31:0] status_summary, mbox_out_wdata, incoming_mailbox, access_control;
  logic [31:1] access_status_in;
  logic mbox_out_we, alert;
  // Reference words by word index, outgoing mailbox, pointer
  logic [31:0] mw [64];
  logic [31:0] mo, rq_addr, rq_data, rd_word;
  logic [7:0] ptr;
  int errors, check_count;
  int nwr = 0, nrd = 0, wait_n = 0;
  ism_top ism_top_inst (.clk(clk), .resetn(resetn), .scl_i(scl), .scl_oe_n(scl_oe_n),
    .sda_i(sda), .sda_oe_n(sda_oe_n), .slave_addr(SADDR), .ibus_req(ibus_req),
    .ibus_rsp(ibus_rsp), .status_summary(status_summary),
    .access_status_in(access_status_in), .mbox_out_we(mbox_out_we),
    .mbox_out_wdata(mbox_out_wdata), .incoming_mailbox(incoming_mailbox),
    .access_control(access_control), .alert(alert));
  ism_i2c_master ism_i2c_master_inst (.scl(scl), .sda(sda), .scl_oe_n(m_scl_oe_n),
    .sda_oe_n(m_sda_oe_n));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  ////////////////////////////////////////
  // Internal bus answers after a random wait
  always @(negedge clk) begin
    ibus_rsp.ack <= 1'b0;
    if (ibus_req.valid && !ibus_rsp.ack) begin
      if (wait_n == 0) begin
        rd_word = $urandom;
        ibus_rsp.ack <= 1'b1;
        ibus_rsp.rdata <= rd_word;
        wait_n <= $urandom_range(6);
        rq_addr <= ibus_req.addr;
        rq_data <= ibus_req.wdata;
        if (ibus_req.we) nwr <= nwr + 1;
        else nrd <= nrd + 1;
      end else wait_n <= wait_n - 1;
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Expected byte at a location
  function automatic logic [7:0] exp_byte(input logic [7:0] p);
    logic [31:0] w;
    case (p[7:2])
      6'h08: w = {access_status_in, |(status_summary & mw[33])};
      6'h20: w = status_summary;
      6'h24: w = mo;
      6'h00, 6'h01, 6'h04, 6'h05, 6'h09, 6'h21, 6'h25: w = mw[p[7:2]];
      default: w = 32'h0000_0000;
    endcase
    return w[8*p[1:0] +: 8];
  endfunction
  function automatic logic [7:0] nxt(input logic [7:0] p, input logic w);
    if (p == 8'h07 && w) return 8'h04;
    if (p == 8'h17 && !w) return 8'h14;
    return p + 8'h01;
  endfunction
  task automatic send(input logic [7:0] d);
    logic [7:0] r;
    logic a;
    ism_i2c_master_inst.byte_io(d, 1'b1, r, a);
    chk({31'h0, a}, 32'h0000_0000);
  endtask
  task automatic wr(input logic [7:0] pa, input int n);
    logic [7:0] d;
    int k;
    ism_i2c_master_inst.start();
    send({SADDR, 1'b0});
    send(pa);
    for (int i = 0; i < n; i++) begin
      d = $urandom;
      k = nwr;
      send(d);
      if (pa[7:2] inside {6'h00, 6'h01, 6'h04, 6'h09, 6'h21, 6'h25})
        mw[pa[7:2]][8*pa[1:0] +: 8] = d;
      if (pa == 8'h07) begin
        chk(nwr, k + 1);
        chk(rq_addr, {mw[0][31:2], 2'b00});
        chk(rq_data, mw[1]);
      end else chk(nwr, k);
      pa = nxt(pa, 1'b1);
    end
    ism_i2c_master_inst.stop();
    ptr = pa;
  endtask
  task automatic rd(input logic setp, input logic [7:0] pa, input int n);
    logic [7:0] r;
    logic a;
    int k;
    ism_i2c_master_inst.start();
    if (setp) begin
      send({SADDR, 1'b0});
      send(pa);
      ism_i2c_master_inst.start();
    end else pa = ptr;
    send({SADDR, 1'b1});
    for (int i = 0; i < n; i++) begin
      k = nrd;
      ism_i2c_master_inst.byte_io(8'hFF, i == n - 1, r, a);
      if (pa == 8'h14) begin
        chk(nrd, k + 1);
        chk(rq_addr, {mw[4][31:2], 2'b00});
        mw[5] = rd_word;
      end else chk(nrd, k);
      chk(r, exp_byte(pa));
      pa = nxt(pa, 1'b0);
    end
    ism_i2c_master_inst.stop();
    ptr = pa;
  endtask
  // New processor-side words, then the alert follows
  task automatic load_side();
    @(negedge clk);
    status_summary = $urandom;
    access_status_in = $urandom;
    mo = $urandom;
    mbox_out_wdata = mo;
    mbox_out_we = 1'b1;
    @(negedge clk);
    mbox_out_we = 1'b0;
    @(negedge clk);
    chk(alert, |(status_summary & mw[33]));
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Hang guard, about 100k cycles
  initial begin
    #(1_000_000);
    errors++;
    stop_test();
  end
  initial begin
    void'($urandom(32'he323));
    {resetn, mbox_out_we, errors, check_count, ptr} = '0;
    {status_summary, access_status_in, mbox_out_wdata, mo} = '0;
    for (int i = 0; i < 64; i++) mw[i] = 32'h0000_0000;
    repeat (4) @(negedge clk);
    resetn = 1'b1;
    repeat (4) @(negedge clk);
    chk(incoming_mailbox, 32'h0000_0000);
    chk(access_control, 32'h0000_0000);
    load_side();
    wr(8'h00, 12);
    rd(1'b1, 8'h00, 9);
    wr(8'h10, 4);
    rd(1'b1, 8'h14, 6);
    wr(8'h17, 1);
    rd(1'b0, 8'h00, 2);
    wr(8'h1E, 8);
    rd(1'b1, 8'h1E, 12);
    wr(8'h7E, 12);
    load_side();
    rd(1'b1, 8'h7E, 12);
    wr(8'h8E, 10);
    rd(1'b1, 8'h8E, 10);
    wr(8'hFE, 4);
    rd(1'b0, 8'h00, 2);
    $display("test directed done");
    repeat (20) begin
      load_side();
      wr($urandom, $urandom_range(1, 5));
      rd($urandom_range(1), $urandom, $urandom_range(1, 5));
    end
    chk(incoming_mailbox, mw[37]);
    chk(access_control, mw[9]);
    $display("test random done");
    stop_test();
  end
endmodule
`default_nettype wire
